/* core/dual_channel_timer_pwm.sv */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
// Notes on behaviour
// - after reset both counters are stopped, with no clearing source
// - setting a channel start bit makes its counter increment
// - overflow sets wrap flag; request raised when wrap enable is set
// - after overflow the counter continues upward from zero
// - compare match on chosen register sets its flag and clears counter
// - a set match flag with its enable raises that request
// - prescaler picks system clock or clock divided by two, four, eight
// - external clock counts on rising, falling or both edges
// - compare match drives its pin low, high or toggles it
// - pin left unchanged when configured level already equals it
// - match fires as counter leaves matching value, pin action then
// - selected edge on capture pin copies count into its register
// - capture on a general register may clear the counter
// - in synchronous mode a counter write presets both counters
// - synchronous clear follows the other channel's clear
// - pwm uses register a as period, b to d as duty
// - polarity 0: duty low, period high; polarity 1 the reverse
// - pwm initial level is one when initial bit equals polarity
// - in pwm match a also clears the counter
// - both channels together give up to six pwm phases
// - counter and general registers are 16 bits, whole-word access only
module dual_channel_timer_pwm
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_clock,
  input wire logic [1:0][3:0] io_pin_in,
  output logic [1:0][3:0] io_pin_out,
  output logic [1:0][3:0] io_pin_oe,
  output logic [1:0][4:0] irq_req
);

  // software state
  logic [1:0] start_q;
  logic sync_q;
  logic [1:0] pwm_q;
  cnt_ctrl_t ctrl_q [2];
  pin_act_t act_q [2][4];
  logic [4:0] ien_q [2];
  logic [4:0] flag_q [2];
  logic [3:0] init_q [2];
  logic [2:0] pol_q [2];
  logic [15:0] cnt_q [2];
  logic [15:0] gr_q [2][4];
  // timing and pin sampling
  logic [2:0] div_q;
  logic ext_s1_q, ext_s2_q, ext_prev_q;
  logic [1:0][3:0] pin_s1_q, pin_s2_q, pin_prev_q;
  // bus decode
  logic hit, is16, ch, err_d, acc, wr_en;
  logic [5:0] off;
  logic [31:0] rdata_d;
  // per channel events
  logic [1:0] tick, wrap, own_clr, clr, cnt_wr, load, load_q;
  logic [1:0][4:0] flag_w1c;
  logic [1:0][3:0] match, capt;

  function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    case (sel)
      EDGE_RISE: edge_hit = cur & ~prev;
      EDGE_FALL: edge_hit = ~cur & prev;
      default: edge_hit = cur ^ prev;
    endcase
  endfunction : edge_hit

  function automatic logic psc_tick(input logic [2:0] sel, input logic [2:0] div,
                                    input logic ext);
    case (sel)
      PSC_DIV1: psc_tick = 1'b1;
      PSC_DIV2: psc_tick = div[0];
      PSC_DIV4: psc_tick = &div[1:0];
      PSC_DIV8: psc_tick = &div;
      PSC_EXT: psc_tick = ext;
      default: psc_tick = 1'b0;
    endcase
  endfunction : psc_tick

  // address decode; setup cycle decides error so the answer comes from flops
  always_comb begin
    ch = (paddr[7:6] == CH1_PAGE);
    off = paddr[5:0];
    is16 = 1'b0;
    if (paddr[7:6] == 2'h0) begin
      hit = (paddr == START_OFF) || (paddr == MODE_OFF);
    end else if (paddr[7:6] == CH0_PAGE || paddr[7:6] == CH1_PAGE) begin
      hit = (off[1:0] == 2'h0) && (off <= GRD_OFF);
      is16 = (off >= CNT_OFF);
    end else begin
      hit = 1'b0;
    end
    // byte writes to 16-bit registers are refused as a whole
    err_d = !hit || (pwrite && is16 && pstrb[1:0] != 2'h3) || (pwrite && !pstrb[0]);
  end

  assign acc = psel && penable && pready && !pslverr;
  assign wr_en = acc && pwrite;

  // read data mux, sampled in the setup cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == START_OFF) begin
      rdata_d[1:0] = start_q;
    end else if (paddr == MODE_OFF) begin
      rdata_d[MODE_SYNC_BIT] = sync_q;
      rdata_d[MODE_PWM_BIT +: 2] = pwm_q;
    end else if (hit) begin
      case (off)
        CTRL_OFF: rdata_d[7:0] = ctrl_q[ch];
        ACT_OFF: begin
          for (int p = 0; p < 4; p++) begin
            rdata_d[p*ACT_SLOT +: 3] = act_q[ch][p];
          end
        end
        IEN_OFF: rdata_d[4:0] = ien_q[ch];
        FLAG_OFF: rdata_d[4:0] = flag_q[ch];
        INIT_OFF: rdata_d[3:0] = init_q[ch];
        POL_OFF: rdata_d[2:0] = pol_q[ch];
        CNT_OFF: rdata_d[15:0] = cnt_q[ch];
        default: rdata_d[15:0] = gr_q[ch][off[3:2] - 2'h3];
      endcase
    end
  end

  // apb answer: one access cycle, pready and data registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= err_d;
        prdata <= err_d ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  // shared divider, sampled as enables; one clock domain only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 3'h0;
    else div_q <= div_q + 3'h1;
  end

  // two-stage synchronisers; logic reads the second stage and one further delay flop for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_prev_q <= '0;
    end else begin
      ext_s1_q <= external_count_clock;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      pin_s1_q <= io_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // count enables, matches, captures and clearing sources
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      tick[c] = start_q[c] && psc_tick(ctrl_q[c].psc_sel, div_q,
                edge_hit(ext_prev_q, ext_s2_q, ctrl_q[c].edge_sel));
      wrap[c] = tick[c] && (cnt_q[c] == CNT_MAX);
      for (int p = 0; p < 4; p++) begin
        // match only as the counter leaves the value, on its own count enable
        match[c][p] = tick[c] && (cnt_q[c] == gr_q[c][p]) &&
                      !(act_q[c][p].capture && !(pwm_q[c] && p != 0));
        capt[c][p] = act_q[c][p].capture && !(pwm_q[c] && p != 0) &&
                     edge_hit(pin_prev_q[c][p], pin_s2_q[c][p], act_q[c][p].code);
      end
      if (pwm_q[c]) begin
        own_clr[c] = match[c][0];
      end else if (ctrl_q[c].clr_sel >= CLR_GRA && ctrl_q[c].clr_sel < CLR_SYNC) begin
        own_clr[c] = match[c][ctrl_q[c].clr_sel[1:0] - 2'h1] ||
                     capt[c][ctrl_q[c].clr_sel[1:0] - 2'h1];
      end else begin
        own_clr[c] = 1'b0;
      end
      cnt_wr[c] = wr_en && paddr[7:6] != 2'h0 && off == CNT_OFF &&
                  (ch == c[0] || sync_q);
      flag_w1c[c] = (wr_en && paddr[7:6] != 2'h0 && ch == c[0] && off == FLAG_OFF) ?
                    pwdata[4:0] : 5'h00;
      load[c] = wr_en && ((paddr[7:6] != 2'h0 && ch == c[0] && (off == INIT_OFF || off == POL_OFF))
                || paddr == MODE_OFF);
    end
    for (int c = 0; c < 2; c++) begin
      clr[c] = own_clr[c] || (sync_q && ctrl_q[c].clr_sel == CLR_SYNC && own_clr[1-c]);
    end
  end

  // global control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 2'h0;
      sync_q <= 1'b0;
      pwm_q <= 2'h0;
    end else if (wr_en && paddr == START_OFF) begin
      start_q <= pwdata[1:0];
    end else if (wr_en && paddr == MODE_OFF) begin
      sync_q <= pwdata[MODE_SYNC_BIT];
      pwm_q <= pwdata[MODE_PWM_BIT +: 2];
    end
  end

  // per channel configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_q[c] <= '0;
        ien_q[c] <= 5'h00;
        init_q[c] <= 4'h0;
        pol_q[c] <= 3'h0;
        for (int p = 0; p < 4; p++) act_q[c][p] <= '0;
      end
    end else if (wr_en && paddr[7:6] != 2'h0) begin
      case (off)
        CTRL_OFF: ctrl_q[ch] <= pwdata[7:0];
        ACT_OFF: begin
          for (int p = 0; p < 4; p++) act_q[ch][p] <= pwdata[p*ACT_SLOT +: 3];
        end
        IEN_OFF: ien_q[ch] <= pwdata[4:0];
        INIT_OFF: init_q[ch] <= pwdata[3:0];
        POL_OFF: pol_q[ch] <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // counters: software write wins, then clear, then count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q[0] <= CNT_ZERO;
      cnt_q[1] <= CNT_ZERO;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cnt_wr[c]) cnt_q[c] <= pwdata[15:0];
        else if (start_q[c] && clr[c]) cnt_q[c] <= CNT_ZERO;
        else if (tick[c]) cnt_q[c] <= cnt_q[c] + 16'h0001;
      end
    end
  end

  // general registers: a capture and a software write in one cycle, capture wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < 4; p++) gr_q[c][p] <= GR_RESET;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < 4; p++) begin
          if (capt[c][p]) gr_q[c][p] <= cnt_q[c];
          else if (wr_en && paddr[7:6] != 2'h0 && ch == c[0] && is16 &&
                   off == GRA_OFF + 6'(p * 4)) gr_q[c][p] <= pwdata[15:0];
        end
      end
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q[0] <= 5'h00;
      flag_q[1] <= 5'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        flag_q[c] <= (flag_q[c] & ~flag_w1c[c]) | {wrap[c], match[c] | capt[c]};
      end
    end
  end

  // request lines per event, gated by the enable bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_req <= '0;
    else begin
      for (int c = 0; c < 2; c++) begin
        irq_req[c] <= flag_q[c] & ien_q[c];
      end
    end
  end

  // reload a cycle after the write, so new mode, initial and polarity bits are all in place
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) load_q <= 2'h0;
    else load_q <= load;
  end

  // pin levels; pwm pins b..d follow period and duty matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pin_out <= '0;
      io_pin_oe <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < 4; p++) begin
          if (pwm_q[c] && p != 0) begin
            io_pin_oe[c][p] <= 1'b1;
            if (load_q[c]) begin
              io_pin_out[c][p] <= ~(init_q[c][p] ^ pol_q[c][p-1]);
            end else if (match[c][0]) begin
              // zero duty would pulse for one count, so it is held at the duty level
              io_pin_out[c][p] <= (gr_q[c][p] == CNT_ZERO) ? pol_q[c][p-1] :
                                  ~pol_q[c][p-1];
            end else if (match[c][p] && gr_q[c][p] < gr_q[c][0]) begin
              io_pin_out[c][p] <= pol_q[c][p-1];
            end
          end else begin
            io_pin_oe[c][p] <= !act_q[c][p].capture && act_q[c][p].code != ACT_NONE;
            if (load_q[c]) begin
              io_pin_out[c][p] <= init_q[c][p];
            end else if (match[c][p] && !act_q[c][p].capture) begin
              // a set level equal to the pin leaves it as it was
              case (act_q[c][p].code)
                ACT_LOW: io_pin_out[c][p] <= 1'b0;
                ACT_HIGH: io_pin_out[c][p] <= 1'b1;
                ACT_TOGGLE: io_pin_out[c][p] <= ~io_pin_out[c][p];
                default: ;
              endcase
            end
          end
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wrap_sets_flag: assert property (wrap[0] |=> flag_q[0][WRAP_BIT])
    else $error("wrap did not set flag");
  a_wrap_restarts: assert property (wrap[0] && !cnt_wr[0] |=> cnt_q[0] == CNT_ZERO)
    else $error("counter not zero after wrap");
  a_match_clears: assert property (!pwm_q[0] && ctrl_q[0].clr_sel == CLR_GRA && match[0][0]
      && !cnt_wr[0] |=> cnt_q[0] == CNT_ZERO && flag_q[0][0])
    else $error("match a did not clear counter");
  a_match_request: assert property (flag_q[0][0] && ien_q[0][0] |=> irq_req[0][0])
    else $error("match request missing");
  a_div_eight: assert property (ctrl_q[0].psc_sel == PSC_DIV8 && tick[0]
      |-> div_q == 3'h7)
    else $error("divide by eight misaligned");
  a_stopped_hold: assert property (!start_q[0] && !cnt_wr[0] |=> $stable(cnt_q[0]))
    else $error("stopped counter moved");
  a_pwm_period: assert property (pwm_q[0] && match[0][0] && !cnt_wr[0]
      |=> cnt_q[0] == CNT_ZERO)
    else $error("pwm period did not clear");
  a_pwm_duty: assert property (pwm_q[0] && match[0][1] && !match[0][0] && !load_q[0]
      && gr_q[0][1] < gr_q[0][0] |=> io_pin_out[0][1] == $past(pol_q[0][0]))
    else $error("duty match level wrong");
  a_capture_copy: assert property (capt[1][0] |=> gr_q[1][0] == $past(cnt_q[1]))
    else $error("capture value wrong");
  a_toggle_pin: assert property (!pwm_q[0] && match[0][3] && !act_q[0][3].capture
      && act_q[0][3].code == ACT_TOGGLE && !load_q[0]
      |=> io_pin_out[0][3] != $past(io_pin_out[0][3]))
    else $error("toggle missed");
  a_sync_clear: assert property (sync_q && ctrl_q[1].clr_sel == CLR_SYNC && own_clr[0]
      && start_q[1] && !cnt_wr[1] |=> cnt_q[1] == CNT_ZERO)
    else $error("synchronous clear missed");

endmodule : dual_channel_timer_pwm

/* core/timer_pkg.sv */
package timer_pkg;
  // register word offsets (byte addresses on apb)
  localparam logic [7:0] START_OFF = 8'h00;
  localparam logic [7:0] MODE_OFF = 8'h04;
  localparam logic [1:0] CH0_PAGE = 2'h1; // channel 0 at 0x40..0x7f
  localparam logic [1:0] CH1_PAGE = 2'h2; // channel 1 at 0x80..0xbf
  localparam logic [5:0] CTRL_OFF = 6'h00;
  localparam logic [5:0] ACT_OFF = 6'h04;
  localparam logic [5:0] IEN_OFF = 6'h08;
  localparam logic [5:0] FLAG_OFF = 6'h0c;
  localparam logic [5:0] INIT_OFF = 6'h10;
  localparam logic [5:0] POL_OFF = 6'h14;
  localparam logic [5:0] CNT_OFF = 6'h18;
  localparam logic [5:0] GRA_OFF = 6'h1c; // general regs a..d at +0x1c, 0x20, 0x24, 0x28
  localparam logic [5:0] GRD_OFF = 6'h28;
  // mode register fields
  localparam int unsigned MODE_SYNC_BIT = 0;
  localparam int unsigned MODE_PWM_BIT = 1; // bit 1 channel 0, bit 2 channel 1
  // prescaler_select codes
  localparam logic [2:0] PSC_DIV1 = 3'h0;
  localparam logic [2:0] PSC_DIV2 = 3'h1;
  localparam logic [2:0] PSC_DIV4 = 3'h2;
  localparam logic [2:0] PSC_DIV8 = 3'h3;
  localparam logic [2:0] PSC_EXT = 3'h4;
  // clock_edge_select and capture edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // clear source codes: 1..4 pick general reg a..d, 5 follows the other channel
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_GRA = 3'h1;
  localparam logic [2:0] CLR_SYNC = 3'h5;
  // pin action codes in compare mode
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam int unsigned ACT_SLOT = 4; // bits per pin in pin_action_reg
  localparam int unsigned WRAP_BIT = 4; // flag and enable bit of the wrap event
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] GR_RESET = 16'hffff;
  // counter_control_reg layout: [7:5] clear source, [4:3] edge, [2:0] prescaler
  typedef struct packed {
    logic [2:0] clr_sel;
    logic [1:0] edge_sel;
    logic [2:0] psc_sel;
  } cnt_ctrl_t;
  // one pin slot: [2] capture mode, [1:0] action or capture edge
  typedef struct packed {
    logic capture;
    logic [1:0] code;
  } pin_act_t;
endpackage : timer_pkg

/* sim/pin_partner.sv */
`timescale 1ns/100ps
// capture sources, loads and count clock source on the timer pins
module pin_partner
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic [1:0][3:0] io_pin_out,
  input wire logic [1:0][3:0] io_pin_oe,
  output logic external_count_clock,
  output logic [1:0][3:0] io_pin_in
);
  logic [1:0][3:0] src_q;
  // a driven pin reads back the device level, an undriven one the source level
  assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & src_q);
  initial begin
    src_q = '0;
    external_count_clock = 1'b0;
  end
  // count clock stands low between bursts; hold picks a prompt or slow source
  task automatic ext_pulses(input int n, input int hold);
    repeat (n) begin
      @(posedge pclk);
      external_count_clock <= 1'b1;
      repeat (hold) @(posedge pclk);
      external_count_clock <= 1'b0;
      repeat (hold) @(posedge pclk);
    end
  endtask : ext_pulses
  // one capture level change, kept for three clocks so it cannot be missed
  task automatic cap_edge(input int ch, input int p, input logic lvl);
    @(posedge pclk);
    src_q[ch][p] <= lvl;
    repeat (3) @(posedge pclk);
  endtask : cap_edge
endmodule : pin_partner

/* sim/dual_channel_timer_pwm_tb_top.sv */
`timescale 1ns/100ps
module dual_channel_timer_pwm_tb_top;
  import timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, external_count_clock, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r0;
  logic [3:0] pstrb;
  logic [1:0][3:0] io_pin_in, io_pin_out, io_pin_oe;
  logic [1:0][4:0] irq_req;
  logic [17:0] mon;
  int mismatches, checks_done, hb, hc, hd;
  // one flat view for waits: pins [ch*4+p], requests [8+ch*5+k]
  assign mon = {irq_req, io_pin_out};
  always #5 pclk = ~pclk;
  dual_channel_timer_pwm i_dual_channel_timer_pwm (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_clock(external_count_clock), .io_pin_in(io_pin_in),
    .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .irq_req(irq_req));
  pin_partner i_pin_partner (.pclk(pclk), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
    .external_count_clock(external_count_clock), .io_pin_in(io_pin_in));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic hang(input string what);
    mismatches++;
    $display("BAD %0t timeout %s", $time, what);
    test_done();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] ra(input int ch, input logic [5:0] off);
    return {(ch == 1) ? CH1_PAGE : CH0_PAGE, off};
  endfunction : ra
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_lvl(input int i, input logic v);
    int n;
    n = 0;
    while (mon[i] !== v && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (mon[i] !== v) hang("level");
  endtask : wait_lvl
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic s_reset;
    apb(0, ra(0, CTRL_OFF), 0, 4'hf);
    chk(rd, 0, "ctrl0 reset");
    apb(0, ra(1, CTRL_OFF), 0, 4'hf);
    chk(rd, 0, "ctrl1 reset");
    apb(0, ra(0, GRA_OFF), 0, 4'hf);
    chk(rd, {16'h0, GR_RESET}, "gr reset");
    apb(0, 8'hfc, 0, 4'hf);
    chk(err, 1, "unmapped read");
    apb(1, ra(0, CNT_OFF), 32'h1234, 4'h1);
    chk(err, 1, "byte write refused");
    apb(0, ra(0, CNT_OFF), 0, 4'hf);
    chk(rd, 0, "count kept");
  endtask : s_reset
  task automatic s_overflow;
    apb(1, ra(0, CNT_OFF), 32'hfffe, 4'hf);
    apb(1, ra(0, IEN_OFF), 32'h10, 4'hf);
    apb(1, START_OFF, 32'h1, 4'hf);
    wait_lvl(8 + WRAP_BIT, 1'b1);
    apb(0, ra(0, FLAG_OFF), 0, 4'hf);
    chk(rd[WRAP_BIT], 1, "wrap flag");
    apb(0, ra(0, CNT_OFF), 0, 4'hf);
    chk(rd < 32'h40, 1, "restart at zero");
  endtask : s_overflow
  // two reads 64 clocks apart see 64 >> k ticks with a free-running divider
  task automatic s_prescale;
    do_reset();
    apb(1, START_OFF, 32'h1, 4'hf);
    for (int k = 0; k < 4; k++) begin
      apb(1, ra(0, CTRL_OFF), 32'(k), 4'hf);
      apb(0, ra(0, CNT_OFF), 0, 4'hf);
      r0 = rd;
      repeat (61) @(posedge pclk);
      apb(0, ra(0, CNT_OFF), 0, 4'hf);
      chk(rd - r0, 32'd64 >> k, "prescale ticks");
    end
  endtask : s_prescale
  task automatic s_ext;
    do_reset();
    apb(1, START_OFF, 32'h1, 4'hf);
    for (int k = 0; k < 3; k++) begin
      apb(1, ra(0, CTRL_OFF), {27'h0, 2'(k), PSC_EXT}, 4'hf);
      apb(0, ra(0, CNT_OFF), 0, 4'hf);
      r0 = rd;
      i_pin_partner.ext_pulses(5, 2 + k);
      repeat (6) @(posedge pclk);
      apb(0, ra(0, CNT_OFF), 0, 4'hf);
      chk(rd - r0, (k == 2) ? 32'd10 : 32'd5, "edge count");
    end
  endtask : s_ext
  // div8 leaves time to read the count right after the pin moves
  task automatic s_compare;
    do_reset();
    apb(1, ra(0, GRA_OFF), 40, 4'hf);
    for (int p = 1; p < 4; p++) apb(1, ra(0, GRA_OFF + 6'(4 * p)), 10, 4'hf);
    apb(1, ra(0, ACT_OFF), 32'h3120, 4'hf);
    apb(1, ra(0, IEN_OFF), 32'h1, 4'hf);
    apb(1, ra(0, CTRL_OFF), {24'h0, CLR_GRA, 2'b00, PSC_DIV8}, 4'hf);
    apb(1, START_OFF, 32'h1, 4'hf);
    wait_lvl(1, 1'b1);
    apb(0, ra(0, CNT_OFF), 0, 4'hf);
    chk(rd, 11, "match as count leaves");
    chk({io_pin_oe[0][3:1], io_pin_out[0][3:1]}, 6'b111101, "pin actions");
    wait_lvl(8, 1'b1);
    apb(0, ra(0, FLAG_OFF), 0, 4'hf);
    chk(rd[0], 1, "match flag a");
    wait_lvl(3, 1'b0);
  endtask : s_compare
  task automatic s_capture;
    do_reset();
    apb(1, ra(1, ACT_OFF), 32'h4, 4'hf);
    apb(1, ra(1, CTRL_OFF), {24'h0, CLR_GRA, 5'h0}, 4'hf);
    apb(1, START_OFF, 32'h2, 4'hf);
    repeat (100) @(posedge pclk);
    apb(0, ra(1, CNT_OFF), 0, 4'hf);
    r0 = rd;
    i_pin_partner.cap_edge(1, 0, 1'b1);
    repeat (4) @(posedge pclk);
    apb(0, ra(1, GRA_OFF), 0, 4'hf);
    chk(rd >= r0 && rd <= r0 + 20, 1, "captured count");
    apb(0, ra(1, CNT_OFF), 0, 4'hf);
    chk(rd < 32'd30, 1, "cleared on capture");
    i_pin_partner.cap_edge(1, 0, 1'b0);
  endtask : s_capture
  task automatic s_sync;
    do_reset();
    apb(1, MODE_OFF, 32'h1, 4'hf);
    apb(1, ra(0, GRA_OFF), 30, 4'hf);
    apb(1, ra(0, CTRL_OFF), {24'h0, CLR_GRA, 5'h0}, 4'hf);
    apb(1, ra(1, CTRL_OFF), {24'h0, CLR_SYNC, 5'h0}, 4'hf);
    apb(1, ra(0, CNT_OFF), 7, 4'hf);
    apb(0, ra(1, CNT_OFF), 0, 4'hf);
    chk(rd, 7, "sync preset");
    apb(1, START_OFF, 32'h3, 4'hf);
    for (int k = 0; k < 4; k++) begin
      repeat (37) @(posedge pclk);
      apb(0, ra(1, CNT_OFF), 0, 4'hf);
      chk(rd <= 32'd31, 1, "sync clear");
    end
  endtask : s_sync
  // period 21 counts, pin b high for counts 0..5; c and d held constant
  task automatic s_pwm;
    do_reset();
    apb(1, ra(0, INIT_OFF), 32'h8, 4'hf);
    apb(1, ra(0, POL_OFF), 32'h2, 4'hf);
    apb(1, MODE_OFF, 32'h6, 4'hf);
    repeat (2) @(posedge pclk);
    chk({io_pin_out[0][3:1], io_pin_out[1][3:1]}, 6'b001111, "pwm initial");
    chk(io_pin_oe[1][3:1], 3'b111, "second channel phases");
    apb(1, ra(0, GRA_OFF), 20, 4'hf);
    apb(1, ra(0, GRA_OFF + 6'h4), 5, 4'hf);
    apb(1, ra(0, GRA_OFF + 6'h8), 0, 4'hf);
    apb(1, ra(0, GRD_OFF), 25, 4'hf);
    apb(1, START_OFF, 32'h1, 4'hf);
    repeat (100) @(posedge pclk);
    hb = 0;
    hc = 0;
    hd = 0;
    repeat (210) begin
      @(posedge pclk);
      hb += (io_pin_out[0][1] === 1'b1);
      hc += (io_pin_out[0][2] === 1'b1);
      hd += (io_pin_out[0][3] === 1'b1);
    end
    chk(hb, 60, "duty b");
    chk({hc[15:0], hd[15:0]}, {16'd210, 16'd210}, "constant duty");
  endtask : s_pwm
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_overflow();
    s_prescale();
    s_ext();
    s_compare();
    s_capture();
    s_sync();
    s_pwm();
    test_done();
  end
endmodule : dual_channel_timer_pwm_tb_top
